// *** hdl/dpss_alarm.sv ***
`timescale 1ns/1ps
// Alarm trigger handshake: one outstanding alarm at a time
module dpss_alarm
   import dpss_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic raise,
   input wire logic sent,
   input wire logic acked,
   output logic notify,
   output logic waiting,
   output logic ack_n,
   output logic accepted
);
   dpss_alarm_state_t state_reg, state_next;
   logic raise_reg;
   logic rise;

   // Rising edge of the host trigger
   assign rise = raise & ~raise_reg;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         DPSS_AL_IDLE: begin
            if (rise) begin
               state_next = DPSS_AL_SEND;
            end
         end
         DPSS_AL_SEND: begin
            if (sent) begin
               state_next = DPSS_AL_WAIT_ACK;
            end
         end
         DPSS_AL_WAIT_ACK: begin
            if (acked) begin
               state_next = DPSS_AL_IDLE;
            end
         end
         default: state_next = DPSS_AL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= DPSS_AL_IDLE;
         raise_reg <= 1'b0;
         notify <= 1'b0;
         waiting <= 1'b0;
         ack_n <= 1'b1;
         accepted <= 1'b0;
      end else begin
         state_reg <= state_next;
         raise_reg <= raise;
         notify <= (state_next == DPSS_AL_SEND);
         waiting <= (state_next != DPSS_AL_IDLE);
         accepted <= rise && (state_reg == DPSS_AL_IDLE);
         // Low once the last alarm is acknowledged, high while one is outstanding
         if (rise && state_reg == DPSS_AL_IDLE) begin
            ack_n <= 1'b1;
         end else if (state_reg == DPSS_AL_WAIT_ACK && acked) begin
            ack_n <= 1'b0;
         end
      end
   end

   AST_ALARM_ACCEPT: assert property (@(posedge clk) disable iff (srst)
      (raise && !$past(raise) && state_reg == DPSS_AL_IDLE) |=> notify && waiting)
      else $error("alarm edge not accepted");
   AST_ALARM_SINGLE: assert property (@(posedge clk) disable iff (srst)
      (state_reg == DPSS_AL_WAIT_ACK && !acked) |=> state_reg == DPSS_AL_WAIT_ACK)
      else $error("second alarm accepted before acknowledge");
   AST_ACK_LOW: assert property (@(posedge clk) disable iff (srst)
      (state_reg == DPSS_AL_WAIT_ACK && acked) |=> !ack_n && !waiting)
      else $error("acknowledge not reported");
endmodule // dpss_alarm

// *** hdl/dpss_status_ctrl.sv ***
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
// Function
// - Error on identity mismatch during parameterization
// - Error on any data link fault
// - Error on cyclic data size mismatch
// - Error clears on next valid response
// - Alarm waiting while alarm not acknowledged
// - Diag waiting while diagnostics not unloaded
// - Station address differs flag from comparison
// - Mapping differs flag from checksum comparison
// - Clear mode bit low in CLEAR
// - Ack bit low after last alarm acknowledged
// - Report own station number
// - Report own mapping checksum
// - Host trigger rising edge raises alarm
// - Host checksum compared with own checksum
// - Cyclic exchange bit only while exchanging
// - Only one alarm outstanding at once
module dpss_status_ctrl
   import dpss_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq,
   input wire logic [7:0] station_num,
   input wire logic [15:0] map_checksum,
   input wire logic param_phase,
   input wire logic identity_differs,
   input wire logic link_fault,
   input wire logic size_differs,
   input wire logic valid_response,
   input wire logic diag_pending,
   input wire logic in_clear,
   input wire logic cyclic_active,
   input wire logic alarm_sent,
   input wire logic alarm_acked,
   output logic alarm_notify,
   output logic error_flag,
   output logic station_addr_differs,
   output logic map_checksum_differs
);
   ////////////////////////////////////////////////////////////////////////////////
   // Host control registers
   logic [7:0] host_station_reg;
   logic [15:0] host_checksum_reg;
   logic alarm_raise_reg;
   logic [3:0] irq_stat_reg;
   logic [3:0] irq_mask_reg;
   logic [3:0] irq_stat_next;
   logic error_next;
   logic error_cause;
   logic addr_diff;
   logic map_diff;
   logic alarm_waiting;
   logic alarm_ack_n;
   logic alarm_accepted;
   logic alarm_notify_w;
   logic diag_waiting;
   logic clear_mode_n;
   logic cyclic_exchange_on;
   logic [3:0] events;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic wr_station;
   logic wr_checksum;
   logic wr_ctrl;
   logic wr_mask;
   logic rd_irq_stat;

   // Write and read decode
   assign wr_station = wr && (addr == DPSS_ADDR_STATION);
   assign wr_checksum = wr && (addr == DPSS_ADDR_CHECKSUM);
   assign wr_ctrl = wr && (addr == DPSS_ADDR_CTRL);
   assign wr_mask = wr && (addr == DPSS_ADDR_IRQ_MASK);
   assign rd_irq_stat = rd && (addr == DPSS_ADDR_IRQ_STAT);

   // Host register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         host_station_reg <= DPSS_STATION_RST;
         host_checksum_reg <= DPSS_CHECKSUM_RST;
         alarm_raise_reg <= 1'b0;
         irq_mask_reg <= 4'h0;
      end else begin
         if (wr_station) begin
            host_station_reg <= wdata[DPSS_STATION_W-1:0];
         end
         if (wr_checksum) begin
            host_checksum_reg <= wdata[DPSS_CHECKSUM_W-1:0];
         end
         if (wr_ctrl) begin
            alarm_raise_reg <= wdata[DPSS_CT_ALARM_RAISE];
         end
         if (wr_mask) begin
            irq_mask_reg <= wdata[DPSS_EV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparisons, evaluated combinationally every cycle
   assign addr_diff = (station_num != host_station_reg);
   assign map_diff = (map_checksum != host_checksum_reg);

   // Error flag: set by any cause, cleared by a valid response; set wins
   assign error_cause = (param_phase && identity_differs) || link_fault || size_differs;
   assign error_next = error_cause ? 1'b1 : (valid_response ? 1'b0 : error_flag);

   // Alarm handshake
   dpss_alarm u_alarm (
      .clk(clk),
      .srst(srst),
      .raise(alarm_raise_reg),
      .sent(alarm_sent),
      .acked(alarm_acked),
      .notify(alarm_notify_w),
      .waiting(alarm_waiting),
      .ack_n(alarm_ack_n),
      .accepted(alarm_accepted)
   );

   // Status flags
   always_ff @(posedge clk) begin
      if (srst) begin
         error_flag <= 1'b0;
         station_addr_differs <= 1'b0;
         map_checksum_differs <= 1'b0;
         diag_waiting <= 1'b0;
         clear_mode_n <= 1'b1;
         cyclic_exchange_on <= 1'b0;
         alarm_notify <= 1'b0;
      end else begin
         error_flag <= error_next;
         station_addr_differs <= addr_diff;
         map_checksum_differs <= map_diff;
         diag_waiting <= diag_pending;
         clear_mode_n <= ~in_clear;
         cyclic_exchange_on <= cyclic_active;
         alarm_notify <= alarm_notify_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt events: sticky, cleared by reading, set wins over clear
   assign events[DPSS_EV_ALARM_SENT] = alarm_accepted;
   assign events[DPSS_EV_ALARM_ACKED] = alarm_acked && alarm_waiting;
   assign events[DPSS_EV_ERROR] = error_next && !error_flag;
   assign events[DPSS_EV_MISMATCH] = (addr_diff && !station_addr_differs) || (map_diff && !map_checksum_differs);
   assign irq_stat_next = (rd_irq_stat ? 4'h0 : irq_stat_reg) | events;

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_stat_reg <= 4'h0;
         irq <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data path
   always_comb begin
      status_word = DPSS_ZERO;
      status_word[DPSS_ST_ERROR] = error_flag;
      status_word[DPSS_ST_ALARM_WAIT] = alarm_waiting;
      status_word[DPSS_ST_DIAG_WAIT] = diag_waiting;
      status_word[DPSS_ST_ADDR_DIFF] = station_addr_differs;
      status_word[DPSS_ST_MAP_DIFF] = map_checksum_differs;
      status_word[DPSS_ST_CLEAR_N] = clear_mode_n;
      status_word[DPSS_ST_ACK_N] = alarm_ack_n;
      status_word[DPSS_ST_CYCLIC] = cyclic_exchange_on;
      status_word[DPSS_ST_IDENT] = identity_differs;
   end

   always_comb begin
      unique case (addr)
         DPSS_ADDR_STATUS: rd_mux = status_word;
         DPSS_ADDR_STATION: rd_mux = {24'h00_0000, station_num};
         DPSS_ADDR_CHECKSUM: rd_mux = {16'h0000, map_checksum};
         DPSS_ADDR_CTRL: rd_mux = {31'h0000_0000, alarm_raise_reg};
         DPSS_ADDR_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat_reg};
         DPSS_ADDR_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask_reg};
         DPSS_ADDR_EVENT: rd_mux = {24'h00_0000, host_station_reg};
         default: rd_mux = DPSS_ZERO;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= DPSS_ZERO;
      end else begin
         rdata <= rd ? rd_mux : DPSS_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_ERR_SET: assert property (@(posedge clk) disable iff (srst)
      (param_phase && identity_differs) |=> error_flag)
      else $error("identity mismatch did not set error");
   AST_ERR_FAULT: assert property (@(posedge clk) disable iff (srst)
      (link_fault || size_differs) |=> error_flag)
      else $error("fault did not set error");
   AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (srst)
      (valid_response && !error_cause) |=> !error_flag)
      else $error("error did not clear on valid response");
   AST_ADDR_CMP: assert property (@(posedge clk) disable iff (srst)
      ##1 station_addr_differs == $past(station_num != host_station_reg))
      else $error("station comparison wrong");
   AST_MAP_CMP: assert property (@(posedge clk) disable iff (srst)
      ##1 map_checksum_differs == $past(map_checksum != host_checksum_reg))
      else $error("checksum comparison wrong");
   AST_CLEAR_POL: assert property (@(posedge clk) disable iff (srst)
      in_clear |=> !clear_mode_n)
      else $error("clear mode polarity wrong");
   AST_CYCLIC: assert property (@(posedge clk) disable iff (srst)
      !cyclic_active |=> !cyclic_exchange_on)
      else $error("cyclic bit set while idle");
   AST_IRQ_RD: assert property (@(posedge clk) disable iff (srst)
      (rd_irq_stat && events == 4'h0) |=> irq_stat_reg == 4'h0 && !irq)
      else $error("interrupt status not cleared by read");
   AST_ERR_HOLD: assert property (@(posedge clk) disable iff (srst)
      (!error_cause && !valid_response) |=> error_flag == $past(error_flag))
      else $error("error flag changed without cause");
   AST_DIAG_SET: assert property (@(posedge clk) disable iff (srst)
      diag_pending |=> diag_waiting)
      else $error("diagnostics waiting not reported");
   AST_DIAG_CLR: assert property (@(posedge clk) disable iff (srst)
      !diag_pending |=> !diag_waiting)
      else $error("diagnostics waiting stuck");
   AST_NOT_CLEAR: assert property (@(posedge clk) disable iff (srst)
      !in_clear |=> clear_mode_n)
      else $error("clear mode bit low outside clear");
   AST_CYCLIC_ON: assert property (@(posedge clk) disable iff (srst)
      cyclic_active |=> cyclic_exchange_on)
      else $error("cyclic bit not set while exchanging");
   AST_RD_STATION: assert property (@(posedge clk) disable iff (srst)
      (rd && addr == DPSS_ADDR_STATION) |=> rdata[DPSS_STATION_W-1:0] == $past(station_num))
      else $error("own station not reported");
   AST_RD_CHECKSUM: assert property (@(posedge clk) disable iff (srst)
      (rd && addr == DPSS_ADDR_CHECKSUM) |=> rdata[DPSS_CHECKSUM_W-1:0] == $past(map_checksum))
      else $error("own checksum not reported");
   AST_RD_WAIT: assert property (@(posedge clk) disable iff (srst)
      (rd && addr == DPSS_ADDR_STATUS) |=> rdata[DPSS_ST_ALARM_WAIT] == $past(alarm_waiting))
      else $error("alarm waiting bit not reported");
   AST_RD_ACK: assert property (@(posedge clk) disable iff (srst)
      (rd && addr == DPSS_ADDR_STATUS) |=> rdata[DPSS_ST_ACK_N] == $past(alarm_ack_n))
      else $error("acknowledge bit not reported");
   AST_RD_ERROR: assert property (@(posedge clk) disable iff (srst)
      (rd && addr == DPSS_ADDR_STATUS) |=> rdata[DPSS_ST_ERROR] == $past(error_flag))
      else $error("error bit not reported");
   AST_RD_IDLE: assert property (@(posedge clk) disable iff (srst)
      !rd |=> rdata == DPSS_ZERO)
      else $error("read data outside read answer");
   AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (srst)
      (irq_mask_reg == 4'h0) |=> !irq)
      else $error("interrupt raised while fully masked");
endmodule // dpss_status_ctrl

// *** shared/dpss_pkg.sv ***
package dpss_pkg;
   // Register indexes on the plain register port
   localparam logic [3:0] DPSS_ADDR_STATUS = 4'h0;
   localparam logic [3:0] DPSS_ADDR_STATION = 4'h1;
   localparam logic [3:0] DPSS_ADDR_CHECKSUM = 4'h2;
   localparam logic [3:0] DPSS_ADDR_CTRL = 4'h3;
   localparam logic [3:0] DPSS_ADDR_IRQ_STAT = 4'h4;
   localparam logic [3:0] DPSS_ADDR_IRQ_MASK = 4'h5;
   localparam logic [3:0] DPSS_ADDR_EVENT = 4'h6;
   // Status word bit positions
   localparam int DPSS_ST_ERROR = 0;
   localparam int DPSS_ST_ALARM_WAIT = 1;
   localparam int DPSS_ST_DIAG_WAIT = 2;
   localparam int DPSS_ST_ADDR_DIFF = 3;
   localparam int DPSS_ST_MAP_DIFF = 4;
   localparam int DPSS_ST_CLEAR_N = 5;
   localparam int DPSS_ST_ACK_N = 6;
   localparam int DPSS_ST_CYCLIC = 7;
   localparam int DPSS_ST_IDENT = 8;
   // Control word bit positions
   localparam int DPSS_CT_ALARM_RAISE = 0;
   // Event bits for the interrupt status
   localparam int DPSS_EV_ALARM_SENT = 0;
   localparam int DPSS_EV_ALARM_ACKED = 1;
   localparam int DPSS_EV_ERROR = 2;
   localparam int DPSS_EV_MISMATCH = 3;
   localparam int DPSS_EV_W = 4;
   // Widths and reset values
   localparam int DPSS_DATA_W = 32;
   localparam int DPSS_STATION_W = 8;
   localparam int DPSS_CHECKSUM_W = 16;
   localparam logic [31:0] DPSS_ZERO = 32'h0000_0000;
   localparam logic [7:0] DPSS_STATION_RST = 8'h00;
   localparam logic [15:0] DPSS_CHECKSUM_RST = 16'h0000;
   // Alarm handshake states
   typedef enum logic [1:0] {DPSS_AL_IDLE, DPSS_AL_SEND, DPSS_AL_WAIT_ACK} dpss_alarm_state_t;
endpackage

// *** testbench/dpss_master_model.sv ***
`timescale 1ns/1ps
// Far-side master: unloads each notified alarm, then acknowledges it after a delay
module dpss_master_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic slow,
   input wire logic alarm_notify,
   output logic alarm_sent,
   output logic alarm_acked
);
   logic [1:0] phase_reg;
   logic [4:0] wait_reg;
   wire logic [4:0] delay = slow ? 5'h14 : 5'h02;
   ////////////////////////////////////////////////////////////////////////
   // Idle, then sent pulse, then acked pulse, each after the delay
   always_ff @(posedge clk) begin
      alarm_sent <= 1'b0;
      alarm_acked <= 1'b0;
      if (srst) begin
         phase_reg <= 2'h0;
         wait_reg <= 5'h00;
      end else if (phase_reg == 2'h0) begin
         wait_reg <= 5'h00;
         if (alarm_notify) begin
            phase_reg <= 2'h1;
         end
      end else if (wait_reg != delay) begin
         wait_reg <= wait_reg + 5'h01;
      end else begin
         wait_reg <= 5'h00;
         alarm_sent <= (phase_reg == 2'h1);
         alarm_acked <= (phase_reg == 2'h2);
         phase_reg <= (phase_reg == 2'h1) ? 2'h2 : 2'h0;
      end
   end
endmodule // dpss_master_model

// *** testbench/dpss_slave_status_control_tb_top.sv ***
`timescale 1ns/1ps
// Bench for the status and control register block
module dp_slave_status_control_tb_top;
   import dpss_pkg::*;
   logic clk, srst, wr, rd, irq, param_phase, identity_differs, link_fault, size_differs;
   logic valid_response, diag_pending, in_clear, cyclic_active, alarm_sent, alarm_acked;
   logic alarm_notify, error_flag, station_addr_differs, map_checksum_differs, slow;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [7:0] station_num;
   logic [15:0] map_checksum;
   int miscompares, compares, cycles;
   ////////////////////////////////////////////////////////////////////////
   // Design and far-side model
   dpss_status_ctrl i_dpss_status_ctrl (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .irq(irq), .station_num(station_num), .map_checksum(map_checksum),
      .param_phase(param_phase), .identity_differs(identity_differs), .link_fault(link_fault),
      .size_differs(size_differs), .valid_response(valid_response), .diag_pending(diag_pending),
      .in_clear(in_clear), .cyclic_active(cyclic_active), .alarm_sent(alarm_sent), .alarm_acked(alarm_acked),
      .alarm_notify(alarm_notify), .error_flag(error_flag), .station_addr_differs(station_addr_differs),
      .map_checksum_differs(map_checksum_differs));
   dpss_master_model i_dpss_master_model (.clk(clk), .srst(srst), .slow(slow), .alarm_notify(alarm_notify),
      .alarm_sent(alarm_sent), .alarm_acked(alarm_acked));
   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic summarize;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Register port cycles and comparison
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_levels;
      rd_reg(DPSS_ADDR_STATUS, d);
      check(d, 32'h0000_0060, "idle status");
      @(posedge clk);
      diag_pending <= 1'b1;
      in_clear <= 1'b1;
      cyclic_active <= 1'b1;
      settle();
      rd_reg(DPSS_ADDR_STATUS, d);
      check(d, 32'h0000_00c4, "busy status");
      @(posedge clk);
      diag_pending <= 1'b0;
      in_clear <= 1'b0;
      cyclic_active <= 1'b0;
      $display("test levels done");
   endtask
   task automatic t_error;
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         param_phase <= (i == 0);
         identity_differs <= (i == 0);
         link_fault <= (i == 1);
         size_differs <= (i == 2);
         settle();
         check({31'h0, error_flag}, 32'h1, "error set");
         @(posedge clk);
         param_phase <= 1'b0;
         identity_differs <= 1'b0;
         link_fault <= 1'b0;
         size_differs <= 1'b0;
         valid_response <= 1'b1;
         settle();
         @(posedge clk);
         valid_response <= 1'b0;
         check({31'h0, error_flag}, 32'h0, "error cleared");
      end
      $display("test error done");
   endtask
   task automatic t_compare;
      @(posedge clk);
      station_num <= 8'h02;
      map_checksum <= 16'h5a3c;
      settle();
      check({30'h0, station_addr_differs, map_checksum_differs}, 32'h3, "diff flags");
      wr_reg(DPSS_ADDR_STATION, 32'h0000_0002);
      wr_reg(DPSS_ADDR_CHECKSUM, 32'h0000_da3c);
      settle();
      check({30'h0, station_addr_differs, map_checksum_differs}, 32'h1, "top bit differs");
      wr_reg(DPSS_ADDR_CHECKSUM, 32'h0000_5a3c);
      wr_reg(4'hf, 32'hffff_ffff);
      settle();
      check({30'h0, station_addr_differs, map_checksum_differs}, 32'h0, "flags match");
      rd_reg(DPSS_ADDR_STATION, d);
      check(d, 32'h0000_0002, "own station");
      rd_reg(DPSS_ADDR_CHECKSUM, d);
      check(d, 32'h0000_5a3c, "own checksum");
      rd_reg(4'hf, d);
      check(d, 32'h0000_0000, "unmapped read");
      $display("test compare done");
   endtask
   task automatic t_alarm;
      rd_reg(DPSS_ADDR_IRQ_STAT, d);
      wr_reg(DPSS_ADDR_IRQ_MASK, 32'h0000_000f);
      wr_reg(DPSS_ADDR_CTRL, 32'h0000_0001);
      settle();
      check({31'h0, alarm_notify}, 32'h1, "notify");
      rd_reg(DPSS_ADDR_STATUS, d);
      check(d & 32'h0000_0042, 32'h0000_0042, "alarm waiting");
      check({31'h0, irq}, 32'h1, "irq on");
      wr_reg(DPSS_ADDR_CTRL, 32'h0000_0000);
      wr_reg(DPSS_ADDR_CTRL, 32'h0000_0001);
      for (int n = 0; n < 100 && alarm_acked !== 1'b1; n++) @(posedge clk);
      settle();
      rd_reg(DPSS_ADDR_STATUS, d);
      check(d & 32'h0000_0042, 32'h0000_0000, "alarm acked");
      check({31'h0, alarm_notify}, 32'h0, "second edge ignored");
      rd_reg(DPSS_ADDR_IRQ_STAT, d);
      check(d, 32'h0000_0003, "irq status");
      settle();
      check({31'h0, irq}, 32'h0, "irq cleared");
      wr_reg(DPSS_ADDR_IRQ_MASK, 32'h0000_0000);
      wr_reg(DPSS_ADDR_CTRL, 32'h0000_0000);
      wr_reg(DPSS_ADDR_CTRL, 32'h0000_0001);
      settle();
      check({31'h0, irq}, 32'h0, "irq masked");
      rd_reg(DPSS_ADDR_IRQ_STAT, d);
      check(d & 32'h0000_0001, 32'h0000_0001, "masked event kept");
      $display("test alarm done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {srst, wr, rd, param_phase, identity_differs, link_fault, size_differs} = 7'h01 << 6;
      {valid_response, diag_pending, in_clear, cyclic_active} = 4'h0;
      {addr, wdata, station_num, map_checksum} = '0;
      slow = 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      t_levels();
      t_error();
      t_compare();
      t_alarm();
      summarize();
   end
endmodule // dp_slave_status_control_tb_top
